// ### hw/ihw_pkg.sv
// Behaviour
// - six sources, each with its own mask
// - accepting an interrupt clears global enable
// - entry takes 12 clocks, vector page 1
// - halt stops cpu clock, interrupt restarts
// - watchdog timeout in halt forces reset
// - falling timer edges set tick flags
// - carrier and key group flags at F0
// - flags read-only, cleared when read
// - reset clears flags, carrier flag undefined
// - request needs flag, mask, global enable
// - timer flags keep setting while halted
// - key pins filtered at slow clock/8
// - high group filter may be bypassed
// - key filters keep running while halted
// - mask set while pin low sets flag
// - masks read/write, 1 enables, reset 0
// - tick masks at F3, others F2
// - vector bits timer, carrier, high, low
// - carrier generation enable F2 bit3, reset 1
// - forced carrier output F0 bit3, reset 0
// - timer plus carrier gives step 0CH
`default_nettype none
package ihw_pkg;
    localparam logic [7:0] ADDR_INPUT_FLAGS = 8'hF0;
    localparam logic [7:0] ADDR_TIMER_FLAGS = 8'hF1;
    localparam logic [7:0] ADDR_INPUT_MASKS = 8'hF2;
    localparam logic [7:0] ADDR_TIMER_MASKS = 8'hF3;
    // bit positions inside the four registers and the vector
    localparam int BIT_CARRIER   = 2;
    localparam int BIT_HIGH_KEYS = 1;
    localparam int BIT_LOW_KEYS  = 0;
    localparam int BIT_SLOW_TICK = 2;
    localparam int BIT_MID_TICK  = 1;
    localparam int BIT_FAST_TICK = 0;
    localparam int BIT_CONTROL   = 3;
    localparam int BIT_VEC_TIMER = 3;
    localparam logic       RST_FORCED_OUT = 1'h0;
    localparam logic       RST_CARRIER_GEN = 1'h1;
    localparam logic       RST_TIMER_RUN  = 1'h0;
    localparam logic [2:0] RST_MASKS      = 3'h0;
    localparam logic [2:0] RST_FLAGS      = 3'h0;
    localparam logic [3:0] VECTOR_PAGE    = 4'h1;
    localparam logic [3:0] ENTRY_CLOCKS   = 4'hC;
    localparam logic [2:0] FILTER_DIV_LAST = 3'h7;
    localparam logic [1:0] FILTER_AGREE   = 2'h2;
    typedef enum logic [2:0] {
        IHW_RUN   = 3'b001,
        IHW_ENTRY = 3'b010,
        IHW_HALT  = 3'b100
    } ihw_state_t;
endpackage : ihw_pkg
`default_nettype wire

// ### hw/ihw_key_filter.sv
`default_nettype none
module ihw_key_filter #(
    parameter int   WIDTH  = 4,
    parameter logic BYPASS = 1'b0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             slow_osc_tick,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] pins_clean
);
    logic [2:0] div;
    logic       strobe;

    // divide the slow oscillator by eight for the sampling strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div    <= 3'h0;
            strobe <= 1'b0;
        end else begin
            strobe <= slow_osc_tick && (div == ihw_pkg::FILTER_DIV_LAST);
            if (slow_osc_tick) begin
                div <= div + 3'h1;
            end
        end
    end

    // two agreeing strobe samples needed, rejects glitches shorter than one period
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        logic [1:0] agree;
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                agree         <= 2'h0;
                pins_clean[i] <= 1'b1;
            end else if (BYPASS) begin
                pins_clean[i] <= pins[i];
            end else if (strobe) begin
                if (pins[i] == pins_clean[i]) begin
                    agree <= 2'h0;
                end else if (agree + 2'h1 == ihw_pkg::FILTER_AGREE) begin
                    agree         <= 2'h0;
                    pins_clean[i] <= pins[i];
                end else begin
                    agree <= agree + 2'h1;
                end
            end
        end
    end
endmodule : ihw_key_filter
`default_nettype wire

// ### hw/ihw_top.sv
// Decided for this implementation: the strobed register port.
`default_nettype none
module ihw_top #(
    parameter logic HIGH_FILTER_BYPASS = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [3:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [3:0] reg_rdata,
    input  wire logic       tick_2hz,
    input  wire logic       tick_8hz,
    input  wire logic       tick_32hz,
    input  wire logic       carrier_event,
    input  wire logic       slow_osc_tick,
    input  wire logic [3:0] low_key_inputs,
    input  wire logic [3:0] high_key_inputs,
    input  wire logic       cpu_ie_set,
    input  wire logic       cpu_ie_clear,
    input  wire logic       cpu_halt,
    input  wire logic       wdt_expired,
    output logic            global_ie,
    output logic            cpu_irq,
    output logic            entry_active,
    output logic      [3:0] vector_page,
    output logic      [3:0] vector_low,
    output logic            cpu_clk_run,
    output logic            init_reset_req,
    output logic            forced_carrier_out,
    output logic            carrier_gen_enable,
    output logic            timer_run,
    output logic            wdt_clear
);
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0]         key_flags;
    logic [2:0]         tick_flags;
    logic [2:0]         key_masks;
    logic [2:0]         tick_masks;
    logic [3:0]         low_clean;
    logic [3:0]         high_clean;
    logic               low_active;
    logic               high_active;
    logic               low_active_d;
    logic               high_active_d;
    logic               low_mask_d;
    logic               high_mask_d;
    logic [2:0]         ticks_d;
    logic [2:0]         key_set;
    logic [2:0]         tick_set;
    logic [2:0]         key_pend;
    logic [2:0]         tick_pend;
    logic               any_pend;
    logic               accept;
    logic [3:0]         entry_cnt;
    logic [3:0]         next_vector;
    ihw_pkg::ihw_state_t state;
    logic               wr_f0;
    logic               wr_f1;
    logic               wr_f2;
    logic               wr_f3;
    logic               rd_f0;
    logic               rd_f1;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    assign wr_f0 = reg_wr && hit(reg_addr, ihw_pkg::ADDR_INPUT_FLAGS);
    assign wr_f1 = reg_wr && hit(reg_addr, ihw_pkg::ADDR_TIMER_FLAGS);
    assign wr_f2 = reg_wr && hit(reg_addr, ihw_pkg::ADDR_INPUT_MASKS);
    assign wr_f3 = reg_wr && hit(reg_addr, ihw_pkg::ADDR_TIMER_MASKS);
    assign rd_f0 = reg_rd && hit(reg_addr, ihw_pkg::ADDR_INPUT_FLAGS);
    assign rd_f1 = reg_rd && hit(reg_addr, ihw_pkg::ADDR_TIMER_FLAGS);

    ////////////////////////////////////////////////////////////////////////////
    // key inputs: filters run on slow oscillator strobes, never gated by halt
    ihw_key_filter #(
        .WIDTH  (4),
        .BYPASS (1'b0)
    ) u_low_filter (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .slow_osc_tick (slow_osc_tick),
        .pins          (low_key_inputs),
        .pins_clean    (low_clean)
    );

    ihw_key_filter #(
        .WIDTH  (4),
        .BYPASS (HIGH_FILTER_BYPASS)
    ) u_high_filter (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .slow_osc_tick (slow_osc_tick),
        .pins          (high_key_inputs),
        .pins_clean    (high_clean)
    );

    // a group is active while any of its pins is low
    assign low_active  = ~&low_clean;
    assign high_active = ~&high_clean;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_active_d  <= 1'b0;
            high_active_d <= 1'b0;
            low_mask_d    <= 1'b0;
            high_mask_d   <= 1'b0;
            ticks_d       <= 3'h0;
        end else begin
            low_active_d  <= low_active;
            high_active_d <= high_active;
            low_mask_d    <= key_masks[ihw_pkg::BIT_LOW_KEYS];
            high_mask_d   <= key_masks[ihw_pkg::BIT_HIGH_KEYS];
            ticks_d       <= {tick_2hz, tick_8hz, tick_32hz};
        end
    end

    // mask re-enable while a pin is held low acts like a fresh falling edge
    assign key_set[ihw_pkg::BIT_LOW_KEYS] = low_active &&
        (!low_active_d || (key_masks[ihw_pkg::BIT_LOW_KEYS] && !low_mask_d));
    assign key_set[ihw_pkg::BIT_HIGH_KEYS] = high_active &&
        (!high_active_d || (key_masks[ihw_pkg::BIT_HIGH_KEYS] && !high_mask_d));
    assign key_set[ihw_pkg::BIT_CARRIER] = carrier_event;
    // falling edges of the timer rates, independent of cpu halt
    assign tick_set = ticks_d & ~{tick_2hz, tick_8hz, tick_32hz};

    ////////////////////////////////////////////////////////////////////////////
    // set wins over clear-on-read so an event in the read cycle survives
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            key_flags <= ihw_pkg::RST_FLAGS;
        end else begin
            key_flags <= key_set | (rd_f0 ? 3'h0 : key_flags);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_flags <= ihw_pkg::RST_FLAGS;
        end else begin
            tick_flags <= tick_set | (rd_f1 ? 3'h0 : tick_flags);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            key_masks          <= ihw_pkg::RST_MASKS;
            carrier_gen_enable <= ihw_pkg::RST_CARRIER_GEN;
        end else if (wr_f2) begin
            key_masks          <= reg_wdata[2:0];
            carrier_gen_enable <= reg_wdata[ihw_pkg::BIT_CONTROL];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_masks <= ihw_pkg::RST_MASKS;
            timer_run  <= ihw_pkg::RST_TIMER_RUN;
        end else if (wr_f3) begin
            tick_masks <= reg_wdata[2:0];
            timer_run  <= reg_wdata[ihw_pkg::BIT_CONTROL];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            forced_carrier_out <= ihw_pkg::RST_FORCED_OUT;
        end else if (wr_f0) begin
            forced_carrier_out <= reg_wdata[ihw_pkg::BIT_CONTROL];
        end
    end

    // watchdog restart is write-one, pulse for one cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdt_clear <= 1'b0;
        end else begin
            wdt_clear <= wr_f1 && reg_wdata[ihw_pkg::BIT_CONTROL];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst || !reg_rd) begin
            reg_rdata <= 4'h0;
        end else begin
            case (reg_addr)
                ihw_pkg::ADDR_INPUT_FLAGS: reg_rdata <= {forced_carrier_out, key_flags};
                ihw_pkg::ADDR_TIMER_FLAGS: reg_rdata <= {1'b0, tick_flags};
                ihw_pkg::ADDR_INPUT_MASKS: reg_rdata <= {carrier_gen_enable, key_masks};
                ihw_pkg::ADDR_TIMER_MASKS: reg_rdata <= {timer_run, tick_masks};
                default:                   reg_rdata <= 4'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign key_pend  = key_flags & key_masks;
    assign tick_pend = tick_flags & tick_masks;
    assign any_pend  = |{key_pend, tick_pend};
    // only one entry at a time; a request during entry waits for it to end
    assign accept    = global_ie && any_pend && (state != ihw_pkg::IHW_ENTRY);

    assign next_vector[ihw_pkg::BIT_VEC_TIMER] = |tick_pend;
    assign next_vector[2:0] = key_pend;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_irq <= 1'b0;
        end else begin
            cpu_irq <= global_ie && any_pend;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            global_ie <= 1'b0;
        end else if (accept) begin
            global_ie <= 1'b0;
        end else if (cpu_ie_set) begin
            global_ie <= 1'b1;
        end else if (cpu_ie_clear) begin
            global_ie <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= ihw_pkg::IHW_RUN;
            entry_cnt <= 4'h0;
        end else begin
            case (state)
                ihw_pkg::IHW_RUN: begin
                    if (accept) begin
                        state     <= ihw_pkg::IHW_ENTRY;
                        entry_cnt <= ihw_pkg::ENTRY_CLOCKS - 4'h1;
                    end else if (cpu_halt) begin
                        state <= ihw_pkg::IHW_HALT;
                    end
                end
                ihw_pkg::IHW_ENTRY: begin
                    if (entry_cnt == 4'h0) begin
                        state <= ihw_pkg::IHW_RUN;
                    end else begin
                        entry_cnt <= entry_cnt - 4'h1;
                    end
                end
                ihw_pkg::IHW_HALT: begin
                    if (accept) begin
                        state     <= ihw_pkg::IHW_ENTRY;
                        entry_cnt <= ihw_pkg::ENTRY_CLOCKS - 4'h1;
                    end
                end
                default: begin
                    state <= ihw_pkg::IHW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            entry_active <= 1'b0;
            cpu_clk_run  <= 1'b1;
        end else begin
            entry_active <= accept || (state == ihw_pkg::IHW_ENTRY && entry_cnt != 4'h0);
            cpu_clk_run  <= accept || !(state == ihw_pkg::IHW_HALT ||
                                        (state == ihw_pkg::IHW_RUN && cpu_halt));
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vector_page <= ihw_pkg::VECTOR_PAGE;
            vector_low  <= 4'h0;
        end else if (accept) begin
            vector_page <= ihw_pkg::VECTOR_PAGE;
            vector_low  <= next_vector;
        end
    end

    // the watchdog keeps counting in halt; its expiry becomes a reset request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            init_reset_req <= 1'b0;
        end else begin
            init_reset_req <= wdt_expired;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_irq_cause: assert property (
        cpu_irq |-> $past(global_ie) && $past(any_pend))
        else $error("request without flag, mask and enable");
    a_entry_len: assert property (
        $rose(entry_active) |-> ##11 entry_active ##1 !entry_active)
        else $error("entry sequence not twelve clocks");
    a_ie_cleared: assert property (
        $rose(entry_active) |-> !global_ie)
        else $error("global enable survived acceptance");
    a_vec_timer: assert property (
        $rose(entry_active) |-> vector_low[3] == $past(|(tick_flags & tick_masks)))
        else $error("timer vector bit wrong");
    a_vec_page: assert property (
        entry_active |-> vector_page == 4'h1 && vector_low != 4'h0)
        else $error("vector outside page one steps 1 to F");
    a_read_clear: assert property (
        rd_f1 && !tick_set[0] |=> !tick_flags[0])
        else $error("tick flag not cleared by read");
    a_tick_set: assert property (
        $fell(tick_2hz) |=> tick_flags[2])
        else $error("falling 2 Hz edge lost");
    a_mask_rearm: assert property (
        high_active && high_active_d && $rose(key_masks[1]) |=> key_flags[1])
        else $error("mask re-enable while low did not set flag");
    a_halt_wake: assert property (
        state == ihw_pkg::IHW_HALT && accept |=> cpu_clk_run ##1 entry_active)
        else $error("accepted request did not wake cpu");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 4'h0)
        else $error("read data outside its cycle");
endmodule : ihw_top
`default_nettype wire

// ### verification/ihw_key_pad.sv
`default_nettype none
module ihw_key_pad #(
    parameter int SLOW_DIV = 4
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       hold_low,
    input  wire logic       hold_high,
    output logic            slow_osc_tick,
    output logic      [3:0] low_key_inputs,
    output logic      [3:0] high_key_inputs
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    ////////////////////////////////////////////////////////////////
    // slow crystal runs on through halt; filters depend on it
    always_ff @(posedge clk) begin
        if (sys_rst || cnt == SLOW_DIV - 1) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
        slow_osc_tick <= !sys_rst && cnt == SLOW_DIV - 1;
    end
    ////////////////////////////////////////////////////////////////
    // released pins go to the pull-up level; holds last well over five clocks
    always_ff @(posedge clk) begin
        low_key_inputs  <= hold_low ? 4'hE : 4'hF;
        high_key_inputs <= hold_high ? 4'h7 : 4'hF;
    end
endmodule : ihw_key_pad
`default_nettype wire

// ### verification/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV  = 4;
    // two agreeing strobes, eight slow ticks apart, plus margin
    localparam int FILT = 4 * 8 * DIV;
    logic       clk, sys_rst, reg_wr, reg_rd, carrier_event, cpu_ie_set, cpu_halt;
    logic       wdt_expired, hold_low, hold_high, slow_osc_tick, global_ie, cpu_irq;
    logic       entry_active, cpu_clk_run, init_reset_req, forced_carrier_out;
    logic       carrier_gen_enable, timer_run, wdt_clear, cpu_ie_clear;
    logic [2:0] ticks;
    logic [7:0] reg_addr;
    logic [3:0] reg_wdata, reg_rdata, vector_page, vector_low, low_keys, high_keys, rd;
    int         fail_count, comparisons;

    ihw_top i_ihw_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tick_2hz(ticks[2]), .tick_8hz(ticks[1]), .tick_32hz(ticks[0]),
        .carrier_event(carrier_event), .slow_osc_tick(slow_osc_tick),
        .low_key_inputs(low_keys), .high_key_inputs(high_keys), .cpu_ie_set(cpu_ie_set),
        .cpu_ie_clear(cpu_ie_clear), .cpu_halt(cpu_halt), .wdt_expired(wdt_expired),
        .global_ie(global_ie), .cpu_irq(cpu_irq), .entry_active(entry_active),
        .vector_page(vector_page), .vector_low(vector_low), .cpu_clk_run(cpu_clk_run),
        .init_reset_req(init_reset_req), .forced_carrier_out(forced_carrier_out),
        .carrier_gen_enable(carrier_gen_enable), .timer_run(timer_run),
        .wdt_clear(wdt_clear));
    ihw_key_pad #(.SLOW_DIV(DIV)) i_ihw_key_pad (.clk(clk), .sys_rst(sys_rst),
        .hold_low(hold_low), .hold_high(hold_high), .slow_osc_tick(slow_osc_tick),
        .low_key_inputs(low_keys), .high_key_inputs(high_keys));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %h want %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask : rdr
    task automatic wait_entry(input int lim);
        int n;
        n = 0;
        while (entry_active !== 1'b1) begin
            if (n == lim) begin
                fail_count++;
                $display("mismatch at %0t: no interrupt entry", $time);
                conclude();
            end else begin
                n++;
                @(posedge clk);
                #1;
            end
        end
    endtask : wait_entry
    task automatic entry_len;
        int n;
        n = 0;
        while (entry_active === 1'b1 && n < 15) begin
            n++;
            @(posedge clk);
            #1;
        end
        chk(4'(n), 4'hC, "entry length");
    endtask : entry_len
    task automatic ie_halt(input logic h);
        @(posedge clk);
        cpu_ie_set <= 1'b1;
        @(posedge clk);
        cpu_ie_set <= 1'b0;
        cpu_halt   <= h;
        @(posedge clk);
        cpu_halt <= 1'b0;
        #1;
    endtask : ie_halt
    ////////////////////////////////////////////////////////////////
    task automatic s_reset;
        logic [3:0] exp [4];
        exp = '{4'h0, 4'h0, 4'h8, 4'h0};
        for (int i = 0; i < 4; i++) begin
            rdr(8'hF0 + 8'(i));
            // carrier flag has no defined reset value
            chk(rd & (i == 0 ? 4'hB : 4'hF), exp[i], "reset");
        end
        rdr(8'h10);
        chk(rd, 4'h0, "unmapped read");
        chk(vector_page, 4'h1, "page");
    endtask : s_reset
    task automatic s_regs;
        wr(8'hF2, 4'h7);
        chk({3'h0, carrier_gen_enable}, 4'h0, "gen enable");
        wr(8'h20, 4'hF);
        rdr(8'hF2);
        chk(rd, 4'h7, "masks F2");
        wr(8'hF3, 4'hF);
        rdr(8'hF3);
        chk(rd, 4'hF, "masks F3");
        wr(8'hF0, 4'hF);
        chk({3'h0, forced_carrier_out}, 4'h1, "forced out");
        rdr(8'hF0);
        chk(rd, 4'h8, "flags read-only");
        wr(8'hF1, 4'hF);
        chk({3'h0, wdt_clear}, 4'h1, "wdt clear");
        rdr(8'hF1);
        chk(rd, 4'h0, "F1 read-only");
        wr(8'hF0, 4'h0);
        wr(8'hF2, 4'h8);
        wr(8'hF3, 4'h8);
    endtask : s_regs
    task automatic s_ticks;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            ticks[i] <= 1'b0;
            @(posedge clk);
            ticks[i] <= 1'b1;
            rdr(8'hF1);
            chk(rd, 4'(1 << i), "tick flag");
            rdr(8'hF1);
            chk(rd, 4'h0, "cleared by read");
        end
    endtask : s_ticks
    task automatic s_accept;
        wr(8'hF3, 4'h9);
        wr(8'hF2, 4'hC);
        // enable then disable: events below must not be taken
        @(posedge clk);
        cpu_ie_set <= 1'b1;
        @(posedge clk);
        cpu_ie_set   <= 1'b0;
        cpu_ie_clear <= 1'b1;
        @(posedge clk);
        cpu_ie_clear  <= 1'b0;
        ticks[0]      <= 1'b0;
        carrier_event <= 1'b1;
        @(posedge clk);
        ticks[0]      <= 1'b1;
        carrier_event <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk({3'h0, cpu_irq | entry_active}, 4'h0, "ie off");
        ie_halt(1'b0);
        wait_entry(10);
        chk(vector_low, 4'hC, "vector");
        chk({3'h0, global_ie}, 4'h0, "ie dropped");
        chk({3'h0, cpu_irq}, 4'h1, "request raised");
        entry_len();
        rdr(8'hF0);
        chk(rd, 4'h4, "carrier flag");
        rdr(8'hF1);
        wr(8'hF3, 4'h8);
        wr(8'hF2, 4'h8);
    endtask : s_accept
    task automatic s_halt;
        wr(8'hF3, 4'hC);
        ie_halt(1'b1);
        repeat (5) @(posedge clk);
        #1;
        chk({3'h0, cpu_clk_run}, 4'h0, "halted");
        @(posedge clk);
        ticks[2] <= 1'b0;
        @(posedge clk);
        ticks[2] <= 1'b1;
        wait_entry(10);
        chk({cpu_clk_run, vector_low[2:0]}, 4'h8, "timer wake");
        entry_len();
        rdr(8'hF1);
        wr(8'hF3, 4'h8);
    endtask : s_halt
    task automatic s_keys;
        @(posedge clk);
        hold_high <= 1'b1;
        repeat (2 * DIV) @(posedge clk);
        hold_high <= 1'b0;
        repeat (FILT) @(posedge clk);
        rdr(8'hF0);
        chk(rd, 4'h0, "glitch rejected");
        wr(8'hF2, 4'h9);
        ie_halt(1'b1);
        @(posedge clk);
        hold_low <= 1'b1;
        wait_entry(FILT * 2);
        chk({cpu_clk_run, vector_low[2:0]}, 4'h9, "key wake");
        entry_len();
        @(posedge clk);
        hold_low <= 1'b0;
        repeat (FILT) @(posedge clk);
        rdr(8'hF0);
        wr(8'hF2, 4'h8);
    endtask : s_keys
    task automatic s_remask;
        @(posedge clk);
        hold_high <= 1'b1;
        repeat (FILT) @(posedge clk);
        rdr(8'hF0);
        chk(rd, 4'h2, "high edge");
        wr(8'hF2, 4'hA);
        rdr(8'hF0);
        chk(rd, 4'h2, "mask set while low");
        @(posedge clk);
        hold_high <= 1'b0;
        repeat (FILT) @(posedge clk);
        wr(8'hF2, 4'h8);
        rdr(8'hF0);
    endtask : s_remask
    task automatic s_wdt;
        @(posedge clk);
        wdt_expired <= 1'b1;
        @(posedge clk);
        wdt_expired <= 1'b0;
        #1;
        chk({3'h0, init_reset_req}, 4'h1, "wdt reset");
    endtask : s_wdt
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {reg_wr, reg_rd, carrier_event, cpu_ie_set, cpu_halt, cpu_ie_clear} = '0;
        {wdt_expired, hold_low, hold_high} = '0;
        sys_rst   = 1'b1;
        ticks     = 3'h7;
        reg_addr  = 8'h00;
        reg_wdata = 4'h0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        s_reset();
        s_regs();
        s_ticks();
        s_accept();
        s_halt();
        s_keys();
        s_remask();
        s_wdt();
        conclude();
    end
endmodule : tb
`default_nettype wire
